// File: rtl/csp_pkg.sv
package csp_pkg;
	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int          CSP_ADDR_W     = 13;
	localparam int          CSP_DATA_W     = 8;
	localparam int          CSP_DEPTH      = 8192;
	localparam logic [12:0] CSP_CLK_BASE   = 13'h1ff8;
	localparam logic [12:0] CSP_CTRL_OFS   = 13'h1ff8;
	localparam logic [12:0] CSP_SEC_OFS    = 13'h1ff9;
	localparam logic [12:0] CSP_MIN_OFS    = 13'h1ffa;
	localparam logic [12:0] CSP_HOUR_OFS   = 13'h1ffb;
	localparam logic [12:0] CSP_WDAY_OFS   = 13'h1ffc;
	localparam logic [12:0] CSP_DATE_OFS   = 13'h1ffd;
	localparam logic [12:0] CSP_MON_OFS    = 13'h1ffe;
	localparam logic [12:0] CSP_YEAR_OFS   = 13'h1fff;
	localparam logic [7:0]  CSP_CTRL_RST   = 8'h00;
	localparam int          CSP_HALT_BIT   = 6;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CSP_CLK_MHZ      = 250;
	localparam int CSP_T_ADDR_NS    = 100;
	localparam int CSP_T_LSEL_NS    = 100;
	localparam int CSP_T_HSEL_NS    = 100;
	localparam int CSP_T_GATE_NS    = 50;
	localparam int CSP_T_HOLD_NS    = 5;
	localparam int CSP_ADDR_CYC = (CSP_T_ADDR_NS * CSP_CLK_MHZ) / 1000;
	localparam int CSP_LSEL_CYC = (CSP_T_LSEL_NS * CSP_CLK_MHZ) / 1000;
	localparam int CSP_HSEL_CYC = (CSP_T_HSEL_NS * CSP_CLK_MHZ) / 1000;
	localparam int CSP_GATE_CYC = (CSP_T_GATE_NS * CSP_CLK_MHZ) / 1000;
	localparam int CSP_HOLD_CYC = ((CSP_T_HOLD_NS * CSP_CLK_MHZ) / 1000 > 0) ?
		(CSP_T_HOLD_NS * CSP_CLK_MHZ) / 1000 : 1;
	localparam int CSP_TICK_CYC = CSP_CLK_MHZ * 1000000;
	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] date;
		logic [7:0] wday;
		logic [7:0] hour;
		logic [7:0] minute;
		logic [7:0] second;
	} csp_time_t;
	typedef struct packed {
		logic       sel_low_n;
		logic       sel_high;
		logic       gate_n;
		logic       wr_n;
	} csp_strobe_t;
	typedef enum logic [1:0] {
		CSP_IDLE  = 2'b00,
		CSP_WAIT  = 2'b01,
		CSP_VALID = 2'b11,
		CSP_HOLD  = 2'b10
	} csp_rd_t;
endpackage

// File: rtl/csp_clock_mapped_sram_port.sv
`timescale 1ns/1ps
module csp_clock_mapped_sram_port #(
	parameter int TICK_CYC = csp_pkg::CSP_TICK_CYC
) (
	input  wire logic                        clk_sys,
	input  wire logic                        rst,
	input  wire logic                        clk_en,
	input  wire logic [csp_pkg::CSP_ADDR_W-1:0] address_lines,
	input  wire logic [csp_pkg::CSP_DATA_W-1:0] data_lines_in,
	output logic      [csp_pkg::CSP_DATA_W-1:0] data_lines_out,
	output logic                             data_lines_oe_n,
	output logic                             data_valid,
	input  wire csp_pkg::csp_strobe_t           strobes,
	input  wire logic                        supply_fail,
	input  wire logic                        on_battery
);
	import csp_pkg::*;

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (TICK_CYC < 1)
	begin : g_bad_tick
		$error("TICK_CYC must be at least 1");
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [12:0] addr_s1_q, addr_q;
	logic [7:0]  din_s1_q, din_q;
	csp_strobe_t stb_s1_q, stb_q;
	logic [1:0]  pwr_s1_q, pwr_q;

	always_ff @(posedge clk_sys)
		if (rst)
		begin
			addr_s1_q <= '0;
			addr_q    <= '0;
			din_s1_q  <= '0;
			din_q     <= '0;
			stb_s1_q  <= 4'b1011;
			stb_q     <= 4'b1011;
			pwr_s1_q  <= 2'b11;
			pwr_q     <= 2'b11;
		end
		else if (clk_en)
		begin
			addr_s1_q <= address_lines;
			addr_q    <= addr_s1_q;
			din_s1_q  <= data_lines_in;
			din_q     <= din_s1_q;
			stb_s1_q  <= strobes;
			stb_q     <= stb_s1_q;
			pwr_s1_q  <= {supply_fail, on_battery};
			pwr_q     <= pwr_s1_q;
		end

	logic dead, sel, rd_mode, wr_mode;
	assign dead    = pwr_q[1] | pwr_q[0];
	assign sel     = !dead && !stb_q.sel_low_n && stb_q.sel_high;
	assign rd_mode = sel && stb_q.wr_n;
	assign wr_mode = sel && !stb_q.wr_n;

	// ----------------------------------------------------------------
	// Memory array
	// ----------------------------------------------------------------
	logic [7:0] mem [CSP_DEPTH];
	logic [7:0] ctrl_q;
	logic       tick;
	logic       upd_q;
	csp_time_t  cnt_q;
	logic       is_clk;
	assign is_clk = (addr_q >= CSP_CLK_BASE);

	always_ff @(posedge clk_sys)
		if (clk_en)
		begin
			if (upd_q && !ctrl_q[CSP_HALT_BIT])
			begin
				mem[CSP_SEC_OFS]  <= cnt_q.second;
				mem[CSP_MIN_OFS]  <= cnt_q.minute;
				mem[CSP_HOUR_OFS] <= cnt_q.hour;
				mem[CSP_WDAY_OFS] <= cnt_q.wday;
				mem[CSP_DATE_OFS] <= cnt_q.date;
				mem[CSP_MON_OFS]  <= cnt_q.month;
				mem[CSP_YEAR_OFS] <= cnt_q.year;
			end
			if (wr_mode)
				mem[addr_q] <= din_q;
		end

	always_ff @(posedge clk_sys)
		if (rst)
			ctrl_q <= CSP_CTRL_RST;
		else if (clk_en && wr_mode && addr_q == CSP_CTRL_OFS)
			ctrl_q <= din_q;

	// ----------------------------------------------------------------
	// Calendar counters
	// ----------------------------------------------------------------
	logic [31:0] div_q;
	assign tick = (div_q == 32'(TICK_CYC - 1));

	always_ff @(posedge clk_sys)
		if (rst)
			div_q <= '0;
		else if (clk_en)
			div_q <= tick ? '0 : div_q + 32'h1;

	// Copy one cycle after the tick, once the counters hold the new time
	always_ff @(posedge clk_sys)
		if (rst)
			upd_q <= 1'b0;
		else if (clk_en)
			upd_q <= tick;

	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
	endfunction

	function automatic logic [7:0] last_day(input logic [7:0] mon, input logic [7:0] yr);
		logic [7:0] bin;
		bin = 8'(yr[7:4] * 10) + {4'h0, yr[3:0]};
		case (mon)
			8'h02:   last_day = (bin[1:0] == 2'b00) ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
			default: last_day = 8'h31;
		endcase
	endfunction

	always_ff @(posedge clk_sys)
		if (rst)
			cnt_q <= '{8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
		else if (clk_en)
		begin
			if (wr_mode && is_clk && addr_q != CSP_CTRL_OFS)
				case (addr_q)
					CSP_SEC_OFS:  cnt_q.second <= din_q;
					CSP_MIN_OFS:  cnt_q.minute <= din_q;
					CSP_HOUR_OFS: cnt_q.hour   <= din_q;
					CSP_WDAY_OFS: cnt_q.wday   <= din_q;
					CSP_DATE_OFS: cnt_q.date   <= din_q;
					CSP_MON_OFS:  cnt_q.month  <= din_q;
					default:      cnt_q.year   <= din_q;
				endcase
			else if (tick)
			begin
				if (cnt_q.second != 8'h59)
					cnt_q.second <= bcd_inc(cnt_q.second);
				else
				begin
					cnt_q.second <= 8'h00;
					if (cnt_q.minute != 8'h59)
						cnt_q.minute <= bcd_inc(cnt_q.minute);
					else
					begin
						cnt_q.minute <= 8'h00;
						if (cnt_q.hour != 8'h23)
							cnt_q.hour <= bcd_inc(cnt_q.hour);
						else
						begin
							cnt_q.hour <= 8'h00;
							cnt_q.wday <= (cnt_q.wday == 8'h07) ? 8'h01 : bcd_inc(cnt_q.wday);
							if (cnt_q.date != last_day(cnt_q.month, cnt_q.year))
								cnt_q.date <= bcd_inc(cnt_q.date);
							else
							begin
								cnt_q.date <= 8'h01;
								if (cnt_q.month != 8'h12)
									cnt_q.month <= bcd_inc(cnt_q.month);
								else
								begin
									cnt_q.month <= 8'h01;
									cnt_q.year  <= (cnt_q.year == 8'h99) ? 8'h00 : bcd_inc(cnt_q.year);
								end
							end
						end
					end
				end
			end
		end

	// ----------------------------------------------------------------
	// Read access timing
	// ----------------------------------------------------------------
	logic [12:0] last_addr_q;
	logic [7:0]  a_cnt_q, s_cnt_q, g_cnt_q, h_cnt_q;
	logic        a_ok, s_ok, g_ok, drive, load;
	csp_rd_t     st_q;
	assign a_ok  = (a_cnt_q >= 8'(CSP_ADDR_CYC));
	assign s_ok  = (s_cnt_q >= 8'(CSP_LSEL_CYC)) && (s_cnt_q >= 8'(CSP_HSEL_CYC));
	assign g_ok  = (g_cnt_q >= 8'(CSP_GATE_CYC));
	assign drive = rd_mode && !stb_q.gate_n;
	assign load  = drive && st_q == CSP_VALID && addr_q == last_addr_q;

	always_ff @(posedge clk_sys)
		if (rst)
		begin
			last_addr_q <= '0;
			a_cnt_q     <= '0;
			s_cnt_q     <= '0;
			g_cnt_q     <= '0;
			h_cnt_q     <= '0;
		end
		else if (clk_en)
		begin
			last_addr_q <= addr_q;
			a_cnt_q     <= (addr_q != last_addr_q) ? 8'h00 : (a_ok ? a_cnt_q : a_cnt_q + 8'h01);
			s_cnt_q     <= !sel ? 8'h00 : (s_ok ? s_cnt_q : s_cnt_q + 8'h01);
			g_cnt_q     <= !drive ? 8'h00 : (g_ok ? g_cnt_q : g_cnt_q + 8'h01);
			h_cnt_q     <= (st_q == CSP_HOLD) ? h_cnt_q + 8'h01 : 8'h00;
		end

	always_ff @(posedge clk_sys)
		if (rst)
			st_q <= CSP_IDLE;
		else if (clk_en)
			case (st_q)
				CSP_IDLE:  st_q <= drive ? CSP_WAIT : CSP_IDLE;
				CSP_WAIT:  st_q <= !drive ? CSP_IDLE :
					(a_ok && s_ok && g_ok && addr_q == last_addr_q) ? CSP_VALID : CSP_WAIT;
				CSP_VALID: st_q <= !drive ? CSP_IDLE : (addr_q != last_addr_q) ? CSP_HOLD : CSP_VALID;
				CSP_HOLD:  st_q <= !drive ? CSP_IDLE :
					(h_cnt_q >= 8'(CSP_HOLD_CYC - 1)) ? CSP_WAIT : CSP_HOLD;
				default:   st_q <= CSP_IDLE;
			endcase

	always_ff @(posedge clk_sys)
		if (rst)
		begin
			data_lines_out  <= '0;
			data_lines_oe_n <= 1'b1;
			data_valid      <= 1'b0;
		end
		else if (clk_en)
		begin
			data_lines_oe_n <= !drive;
			data_valid      <= load || (drive && data_valid &&
				(st_q == CSP_VALID || st_q == CSP_HOLD));
			if (load)
				data_lines_out <= mem[addr_q];
			else if (drive && st_q == CSP_WAIT)
				data_lines_out <= 8'h5a;
		end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_dead_float: assert property (@(posedge clk_sys) disable iff (rst)
		clk_en && dead |=> data_lines_oe_n)
		else $error("Data driven while power failed");
	chk_write_float: assert property (@(posedge clk_sys) disable iff (rst)
		clk_en && !stb_q.wr_n |=> data_lines_oe_n)
		else $error("Data driven during write strobe");
	chk_gate_float: assert property (@(posedge clk_sys) disable iff (rst)
		clk_en && stb_q.gate_n |=> data_lines_oe_n && !data_valid)
		else $error("Data driven with gate high");
	chk_valid_late: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(data_valid) |-> $past(a_ok) && $past(s_ok) && $past(g_ok))
		else $error("Data valid before access times");
	chk_ctrl_write: assert property (@(posedge clk_sys) disable iff (rst)
		clk_en && wr_mode && addr_q == CSP_CTRL_OFS |=> ctrl_q == $past(din_q))
		else $error("Control byte not written");
	chk_halt_hold: assert property (@(posedge clk_sys) disable iff (rst)
		clk_en && upd_q && ctrl_q[CSP_HALT_BIT] && !wr_mode |=>
		mem[CSP_SEC_OFS] == $past(mem[CSP_SEC_OFS]))
		else $error("Clock bytes updated while halted");
	chk_sec_wrap: assert property (@(posedge clk_sys) disable iff (rst)
		clk_en && tick && !wr_mode && cnt_q.second == 8'h59 |=> cnt_q.second == 8'h00)
		else $error("Seconds did not wrap");
	chk_hour_range: assert property (@(posedge clk_sys) disable iff (rst)
		clk_en && tick && !wr_mode && cnt_q.hour == 8'h23 && cnt_q.minute == 8'h59 &&
		cnt_q.second == 8'h59 |=> cnt_q.hour == 8'h00)
		else $error("Hour did not wrap at 24");
	chk_wait_undef: assert property (@(posedge clk_sys) disable iff (rst)
		clk_en && st_q == CSP_WAIT |=> !data_valid)
		else $error("Data valid while access pending");
	chk_sel_float: assert property (@(posedge clk_sys) disable iff (rst)
		clk_en && !sel |=> data_lines_oe_n)
		else $error("Data driven while deselected");
	chk_read_drive: assert property (@(posedge clk_sys) disable iff (rst)
		clk_en && rd_mode && !stb_q.gate_n |=> !data_lines_oe_n)
		else $error("Data not driven in read mode");
	chk_update_copy: assert property (@(posedge clk_sys) disable iff (rst)
		clk_en && upd_q && !ctrl_q[CSP_HALT_BIT] && !wr_mode |=>
		mem[CSP_SEC_OFS] == $past(cnt_q.second))
		else $error("Clock bytes not copied from counters");
endmodule

// File: sim/csp_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host bus master driving the memory strobes
// ----------------------------------------------------------------
module csp_host_model (
	input  wire logic                           clk_sys,
	output logic      [csp_pkg::CSP_ADDR_W-1:0] address_lines,
	output logic      [csp_pkg::CSP_DATA_W-1:0] data_lines_in,
	output csp_pkg::csp_strobe_t                strobes,
	input  wire logic [csp_pkg::CSP_DATA_W-1:0] data_lines_out,
	input  wire logic                           data_lines_oe_n,
	input  wire logic                           data_valid
);
	import csp_pkg::*;
	localparam csp_strobe_t IDLE = '{1'b1, 1'b0, 1'b1, 1'b1};
	initial
	begin
		address_lines = '0;
		data_lines_in = 8'h00;
		strobes       = IDLE;
	end
	// One access: strobes held n cycles or until valid data, then released
	task automatic run(input logic [12:0] a, input logic [7:0] d, input csp_strobe_t s,
		input int n, output int t_drive, output int t_valid, output logic [7:0] q);
		t_drive = -1;
		t_valid = -1;
		q       = 8'h00;
		@(negedge clk_sys);
		address_lines = a;
		data_lines_in = d;
		strobes       = s;
		for (int i = 1; i <= n && t_valid < 0; i++)
		begin
			@(negedge clk_sys);
			if (data_lines_oe_n === 1'b0 && t_drive < 0)
				t_drive = i;
			if (data_valid === 1'b1 && data_lines_oe_n === 1'b0)
			begin
				t_valid = i;
				q       = data_lines_out;
			end
		end
		strobes = IDLE;
		repeat (2) @(negedge clk_sys);
		data_lines_in = ~d;
		repeat (4) @(negedge clk_sys);
	endtask
endmodule

// File: sim/csp_clock_mapped_sram_port_tb.sv
`timescale 1ns/1ps
module csp_clock_mapped_sram_port_tb;
	import csp_pkg::*;
	localparam int TICK = 20000;
	localparam csp_strobe_t RD = '{1'b0, 1'b1, 1'b0, 1'b1};
	localparam csp_strobe_t WR = '{1'b0, 1'b1, 1'b1, 1'b0};
	typedef struct packed { logic [12:0] a; logic [7:0] d; } csp_row_t;
	logic                  clk_sys;
	logic                  rst;
	logic                  clk_en;
	logic                  supply_fail;
	logic                  on_battery;
	logic [CSP_ADDR_W-1:0] address_lines;
	logic [CSP_DATA_W-1:0] data_lines_in;
	logic [CSP_DATA_W-1:0] data_lines_out;
	logic                  data_lines_oe_n;
	logic                  data_valid;
	csp_strobe_t           strobes;
	int                    n_compared;
	int                    mismatches;
	int                    td;
	int                    tv;
	logic [7:0]            q;
	csp_row_t              rows [6] = '{'{13'h0000, 8'ha5}, '{13'h1555, 8'h5a},
		'{13'h0aaa, 8'hc3}, '{13'h1ff7, 8'h7e}, '{13'h1fff, 8'h99}, '{13'h1ffe, 8'h12}};
	csp_strobe_t           probe [4] = '{'{1'b1, 1'b1, 1'b0, 1'b1},
		'{1'b0, 1'b0, 1'b0, 1'b1}, '{1'b0, 1'b1, 1'b1, 1'b1}, RD};
	csp_clock_mapped_sram_port #(.TICK_CYC(TICK)) uut (
		.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .address_lines(address_lines),
		.data_lines_in(data_lines_in), .data_lines_out(data_lines_out),
		.data_lines_oe_n(data_lines_oe_n), .data_valid(data_valid), .strobes(strobes),
		.supply_fail(supply_fail), .on_battery(on_battery));
	csp_host_model host (
		.clk_sys(clk_sys), .address_lines(address_lines), .data_lines_in(data_lines_in),
		.strobes(strobes), .data_lines_out(data_lines_out),
		.data_lines_oe_n(data_lines_oe_n), .data_valid(data_valid));
	// ----------------------------------------------------------------
	// Compare and report
	// ----------------------------------------------------------------
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk1(input string what, input logic exp, input logic got);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic rd(input logic [12:0] a, output logic [7:0] d);
		host.run(a, 8'h00, RD, 60, td, tv, d);
		if (tv < 0)
		begin
			mismatches++;
			$display("ERROR read valid expected 1 seen 0");
			results();
		end
	endtask
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		host.run(a, d, WR, 12, td, tv, q);
		chk1("oe_n in write", 1'b1, td < 0);
	endtask
	// ----------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial
	begin
		rst         = 1'b1;
		clk_en      = 1'b1;
		supply_fail = 1'b0;
		on_battery  = 1'b0;
		n_compared  = 0;
		mismatches  = 0;
		repeat (10) @(negedge clk_sys);
		chk1("oe_n reset", 1'b1, data_lines_oe_n);
		chk1("valid reset", 1'b0, data_valid);
		chk8("out reset", 8'h00, data_lines_out);
		rst = 1'b0;
		repeat (3) @(negedge clk_sys);
		foreach (rows[i])
			wr(rows[i].a, rows[i].d);
		foreach (rows[i])
		begin
			rd(rows[i].a, q);
			chk8("row data", rows[i].d, q);
			chk1("valid after access time", 1'b1, tv >= CSP_ADDR_CYC);
			chk1("drive before valid", 1'b1, td < tv);
		end
		fork
			host.run(13'h0aaa, 8'h00, RD, 80, td, tv, q);
			begin
				repeat (12) @(negedge clk_sys);
				host.address_lines = 13'h1555;
			end
		join
		chk8("data after address change", 8'h5a, q);
		chk1("address time restarted", 1'b1, tv >= 11 + CSP_ADDR_CYC);
		for (int k = 0; k < 4; k++)
		begin
			host.run(13'h0000, 8'h00, probe[k], 12, td, tv, q);
			chk1("drive by selects", k == 3, td >= 0);
		end
		host.run(13'h0100, 8'h3c, '{1'b0, 1'b1, 1'b0, 1'b0}, 12, td, tv, q);
		chk1("oe_n in gated write", 1'b1, td < 0);
		rd(13'h0100, q);
		chk8("gated write data", 8'h3c, q);
		wr(CSP_SEC_OFS, 8'h59);
		rd(CSP_SEC_OFS, q);
		chk8("seconds", 8'h59, q);
		repeat (TICK) @(negedge clk_sys);
		rd(CSP_SEC_OFS, q);
		chk8("seconds wrap", 8'h00, q);
		rd(CSP_MIN_OFS, q);
		chk8("minute carry", 8'h01, q);
		wr(CSP_CTRL_OFS, 8'h40);
		rd(CSP_CTRL_OFS, q);
		chk8("control byte", 8'h40, q);
		repeat (TICK) @(negedge clk_sys);
		rd(CSP_SEC_OFS, q);
		chk8("halted seconds", 8'h00, q);
		wr(CSP_CTRL_OFS, 8'h00);
		wr(CSP_YEAR_OFS, 8'h23);
		wr(CSP_MON_OFS, 8'h02);
		wr(CSP_DATE_OFS, 8'h28);
		wr(CSP_HOUR_OFS, 8'h23);
		wr(CSP_MIN_OFS, 8'h59);
		wr(CSP_SEC_OFS, 8'h59);
		repeat (TICK) @(negedge clk_sys);
		rd(CSP_HOUR_OFS, q);
		chk8("hour wrap", 8'h00, q);
		rd(CSP_DATE_OFS, q);
		chk8("month end date", 8'h01, q);
		rd(CSP_MON_OFS, q);
		chk8("month carry", 8'h03, q);
		for (int f = 0; f < 2; f++)
		begin
			{on_battery, supply_fail} = (f == 0) ? 2'b01 : 2'b10;
			host.run(13'h0000, 8'hff, WR, 12, td, tv, q);
			host.run(13'h0000, 8'h00, RD, 40, td, tv, q);
			chk1("drive in power fail", 1'b0, td >= 0);
			{on_battery, supply_fail} = 2'b00;
			rd(13'h0000, q);
			chk8("kept data", 8'ha5, q);
		end
		clk_en = 1'b0;
		host.run(13'h0000, 8'h00, RD, 12, td, tv, q);
		chk1("drive while disabled", 1'b0, td >= 0);
		clk_en = 1'b1;
		rd(13'h0000, q);
		chk8("data after enable", 8'ha5, q);
		results();
	end
endmodule
